/* File: prr_router.sv */
// peripheral pin router: input selection, output source selection, lock
// assumes: one 50 MHz clock; peripherals and latches on that clock, pins async
`timescale 1ns/1ps
`include "prr_defines.svh"

module prr_router #(
  parameter bit LARGE_VARIANT  = 1'b1,
  parameter bit INACTIVE_LEVEL = 1'b0
) (
  // clock and resets
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  input  wire logic                                  soft_reset,
  // configuration
  input  wire prr_pkg::prr_cfg_wr_t                  cfg_wr,
  input  wire logic                                  one_shot_lock_config,
  output logic                                       routing_frozen_bit,
  output logic                                       cfg_wr_rejected,
  // peripheral side
  input  wire logic [`PRR_CODE_SPACE-1:0]            periph_out,
  input  wire logic [`PRR_CODE_SPACE-1:0]            periph_dir_ovr_req,
  input  wire logic [`PRR_CODE_SPACE-1:0]            periph_dir_ovr_oe_n,
  input  wire logic                                  two_wire_active,
  output logic [`PRR_NUM_IN-1:0]                     periph_in,
  // port side
  input  wire logic [`PRR_NUM_PINS-1:0]              pin_in,
  input  wire logic [`PRR_NUM_PINS-1:0]              port_latch,
  input  wire logic [`PRR_NUM_PINS-1:0]              pin_direction_bit,
  input  wire logic [`PRR_NUM_PINS-1:0]              input_threshold_select,
  output logic [`PRR_NUM_PINS-1:0]                   pin_out,
  output logic [`PRR_NUM_PINS-1:0]                   pin_oe_n,
  output prr_pkg::prr_thr_t [`PRR_NUM_PINS-1:0]      pin_thr
);
  import prr_pkg::*;

  // ==========================================================================
  // elaboration check
  if (`PRR_NUM_PINS > `PRR_CODE_SPACE) begin : g_bad_size
    $error("pin count exceeds code space");
  end
  if (`PRR_NUM_IN > 32 || `PRR_NUM_PINS > 32) begin : g_bad_index
    $error("index field too narrow");
  end
  if (`PRR_CODE_SPACE != 32 || `PRR_SEL_W < 5 || `PRR_SEL_W > 8) begin : g_bad_code
    $error("selection code width not served");
  end
  if (`PRR_IN_SCL >= `PRR_NUM_IN || `PRR_IN_SDA >= `PRR_NUM_IN) begin : g_bad_bus_in
    $error("two-wire input index out of range");
  end

  // ==========================================================================
  // variant constants
  localparam logic [`PRR_NUM_PINS-1:0] PINS_PRESENT =
    LARGE_VARIANT ? `PRR_PINS_LARGE : `PRR_PINS_SMALL;
  localparam logic [`PRR_NUM_IN*`PRR_SEL_W-1:0] IN_DEFAULTS =
    LARGE_VARIANT ? `PRR_IN_DEF_LARGE : `PRR_IN_DEF_SMALL;
  localparam logic [`PRR_CODE_SPACE-1:0] OUT_VALID  = `PRR_OUT_VALID;
  localparam logic [`PRR_CODE_SPACE-1:0] OUT_DIROVR = `PRR_OUT_DIROVR;
  localparam logic [`PRR_NUM_PINS-1:0]   PINS_2WIRE = `PRR_PINS_2WIRE;

  prr_state_t st;
  prr_state_t next_st;

  // ==========================================================================
  // input select: code to pin, absent pins give the inactive level
  function automatic logic pick_pin(input logic [`PRR_SEL_W-1:0] code,
                                    input logic [`PRR_NUM_PINS-1:0] pins);
    logic hit;
    hit = 1'b0;
    if (code < `PRR_SEL_W'(`PRR_NUM_PINS)) begin
      hit = PINS_PRESENT[code[4:0]];
    end
    if (hit) begin
      pick_pin = pins[code[4:0]];
    end else begin
      pick_pin = INACTIVE_LEVEL;
    end
  endfunction

  // ==========================================================================
  // output select: code to peripheral output, unnamed codes fall to latch
  function automatic logic code_named(input logic [`PRR_SEL_W-1:0] code);
    code_named = 1'b0;
    if (code < `PRR_SEL_W'(`PRR_CODE_SPACE)) begin
      code_named = OUT_VALID[code[4:0]];
    end
  endfunction

  // ==========================================================================
  // next state
  always_comb begin
    logic                     sel_wr;
    logic                     two_wire_pin;
    logic [`PRR_SEL_W-1:0]    oc;
    next_st = st;
    sel_wr = cfg_wr.we && (cfg_wr.target == PRR_TGT_INPUT || cfg_wr.target == PRR_TGT_OUTPUT);
    two_wire_pin = 1'b0;
    oc = '0;
    next_st.wr_rejected = 1'b0;

    // pin synchronisers
    next_st.sync1 = pin_in;
    next_st.sync2 = st.sync1;

    // selection writes, independent tables, refused while frozen
    if (sel_wr) begin
      if (st.frozen) begin
        next_st.wr_rejected = 1'b1;
      end else if (cfg_wr.target == PRR_TGT_INPUT) begin
        if (cfg_wr.index < 5'(`PRR_NUM_IN)) begin
          next_st.in_sel[cfg_wr.index] = cfg_wr.data[`PRR_SEL_W-1:0];
        end
      end else begin
        if (cfg_wr.index < 5'(`PRR_NUM_PINS) && PINS_PRESENT[cfg_wr.index]) begin
          next_st.out_sel[cfg_wr.index] = cfg_wr.data[`PRR_SEL_W-1:0];
        end
      end
    end

    // unlock sequence: any other write breaks it
    if (cfg_wr.we) begin
      if (cfg_wr.target == PRR_TGT_LOCK) begin
        case (st.seq)
          PRR_SEQ_ARMED: begin
            next_st.seq = PRR_SEQ_IDLE;
            if (cfg_wr.data[`PRR_LOCK_BIT]) begin
              next_st.frozen = 1'b1;
              if (one_shot_lock_config) begin
                next_st.one_shot_used = 1'b1;
              end
            end else if (one_shot_lock_config && st.one_shot_used) begin
              next_st.wr_rejected = 1'b1;
            end else begin
              next_st.frozen = 1'b0;
            end
          end
          PRR_SEQ_FIRST: begin
            if (cfg_wr.data == `PRR_KEY_SECOND) begin
              next_st.seq = PRR_SEQ_ARMED;
            end else if (cfg_wr.data == `PRR_KEY_FIRST) begin
              next_st.seq = PRR_SEQ_FIRST;
            end else begin
              next_st.seq = PRR_SEQ_IDLE;
              next_st.wr_rejected = 1'b1;
            end
          end
          default: begin
            if (cfg_wr.data == `PRR_KEY_FIRST) begin
              next_st.seq = PRR_SEQ_FIRST;
            end else begin
              next_st.seq = PRR_SEQ_IDLE;
              next_st.wr_rejected = 1'b1;
            end
          end
        endcase
      end else begin
        next_st.seq = PRR_SEQ_IDLE;
      end
    end

    // non power-on reset: lock state rearmed, selections kept
    if (soft_reset) begin
      next_st.frozen = 1'b0;
      next_st.one_shot_used = 1'b0;
      next_st.seq = PRR_SEQ_IDLE;
    end

    // input routing, digital only, runs in sleep too
    for (int i = 0; i < `PRR_NUM_IN; i++) begin
      next_st.periph_in[i] = pick_pin(st.in_sel[i], st.sync2);
    end

    // output routing, driver enable and buffer choice per pin
    for (int p = 0; p < `PRR_NUM_PINS; p++) begin
      oc = st.out_sel[p];
      if (!PINS_PRESENT[p]) begin
        next_st.pin_out[p] = 1'b0;
        next_st.pin_oe_n[p] = 1'b1;
        next_st.pin_thr[p] = PRR_THR_SCHMITT;
      end else begin
        if (code_named(oc)) begin
          next_st.pin_out[p] = periph_out[oc[4:0]];
        end else begin
          next_st.pin_out[p] = port_latch[p];
        end
        if (code_named(oc) && OUT_DIROVR[oc[4:0]] && periph_dir_ovr_req[oc[4:0]]) begin
          next_st.pin_oe_n[p] = periph_dir_ovr_oe_n[oc[4:0]];
        end else begin
          next_st.pin_oe_n[p] = pin_direction_bit[p];
        end
        two_wire_pin = two_wire_active &&
                       (st.in_sel[`PRR_IN_SCL] == `PRR_SEL_W'(p) ||
                        st.in_sel[`PRR_IN_SDA] == `PRR_SEL_W'(p) ||
                        oc == `PRR_OUT_SCL || oc == `PRR_OUT_SDA);
        if (two_wire_pin && PINS_2WIRE[p]) begin
          next_st.pin_thr[p] = PRR_THR_TWO_WIRE;
        end else if (input_threshold_select[p]) begin
          next_st.pin_thr[p] = PRR_THR_SCHMITT;
        end else begin
          next_st.pin_thr[p] = PRR_THR_TTL;
        end
      end
    end
  end

  // ==========================================================================
  // state register; power-on reset restores all defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st.in_sel        <= IN_DEFAULTS;
      st.out_sel       <= {`PRR_NUM_PINS{`PRR_OUT_DEF}};
      st.frozen        <= 1'b0;
      st.one_shot_used <= 1'b0;
      st.seq           <= PRR_SEQ_IDLE;
      st.wr_rejected   <= 1'b0;
      st.sync1         <= '0;
      st.sync2         <= '0;
      st.periph_in     <= '0;
      st.pin_out       <= '0;
      st.pin_oe_n      <= '1;
      st.pin_thr       <= {`PRR_NUM_PINS{PRR_THR_SCHMITT}};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs straight from state
  assign routing_frozen_bit = st.frozen;
  assign cfg_wr_rejected    = st.wr_rejected;
  assign periph_in          = st.periph_in;
  assign pin_out            = st.pin_out;
  assign pin_oe_n           = st.pin_oe_n;
  always_comb begin
    for (int p = 0; p < `PRR_NUM_PINS; p++) begin
      pin_thr[p] = prr_thr_t'(st.pin_thr[p]);
    end
  end

endmodule // prr_router

/* File: prr_defines.svh */
// constants for the peripheral pin router: codes, reset values, masks
// assumes: included by its bare name from the package and the router
`ifndef PRR_DEFINES_SVH
`define PRR_DEFINES_SVH

// ==========================================================================
// sizes
`define PRR_NUM_IN      20
`define PRR_NUM_PINS    24
`define PRR_SEL_W       6
`define PRR_CODE_SPACE  32

// ==========================================================================
// lock register unlock keys and lock bit position
`define PRR_KEY_FIRST   8'h55
`define PRR_KEY_SECOND  8'haa
`define PRR_LOCK_BIT    0

// ==========================================================================
// input selection reset values, index 0 (external interrupt) in the low field
`define PRR_IN_DEF_SMALL {6'h10, 6'h11, 6'h14, 6'h15, 6'h13, 6'h11, 6'h10, 6'h12, 6'h05, 6'h11, \
                          6'h14, 6'h13, 6'h02, 6'h13, 6'h15, 6'h05, 6'h04, 6'h05, 6'h02, 6'h02}
`define PRR_IN_DEF_LARGE {6'h10, 6'h11, 6'h0f, 6'h0d, 6'h16, 6'h0c, 6'h0e, 6'h12, 6'h0d, 6'h0c, \
                          6'h13, 6'h02, 6'h02, 6'h13, 6'h15, 6'h05, 6'h04, 6'h05, 6'h02, 6'h02}
`define PRR_OUT_DEF     6'h00

// ==========================================================================
// pin index = port * 8 + bit (a: 0-7, b: 8-15, c: 16-23)
`define PRR_PINS_SMALL  24'h3f003f
`define PRR_PINS_LARGE  24'hfff03f
`define PRR_PINS_2WIRE  24'h180600

// ==========================================================================
// output source codes
`define PRR_OUT_VALID   32'h0e7ffffe
`define PRR_OUT_DIROVR  32'h00678000
`define PRR_OUT_SCL     6'h15
`define PRR_OUT_SDA     6'h16

// ==========================================================================
// peripheral input indices of the two-wire clock and data
`define PRR_IN_SCL      13
`define PRR_IN_SDA      14

`endif

/* File: prr_pkg.sv */
// types shared by the peripheral pin router and its surroundings
// assumes: prr_defines.svh on the include path
package prr_pkg;
  `include "prr_defines.svh"

  // ========================================================================
  // configuration write port
  typedef enum logic [1:0] {
    PRR_TGT_INPUT,
    PRR_TGT_OUTPUT,
    PRR_TGT_LOCK,
    PRR_TGT_NONE
  } prr_target_t;

  typedef struct packed {
    logic        we;
    prr_target_t target;
    logic [4:0]  index;
    logic [7:0]  data;
  } prr_cfg_wr_t;

  // ========================================================================
  // pin input buffer choice
  typedef enum logic [1:0] {
    PRR_THR_TTL,
    PRR_THR_SCHMITT,
    PRR_THR_TWO_WIRE
  } prr_thr_t;

  typedef enum logic [1:0] {
    PRR_SEQ_IDLE,
    PRR_SEQ_FIRST,
    PRR_SEQ_ARMED
  } prr_seq_t;

  // ========================================================================
  // whole router state
  typedef struct packed {
    logic [`PRR_NUM_IN-1:0][`PRR_SEL_W-1:0]   in_sel;
    logic [`PRR_NUM_PINS-1:0][`PRR_SEL_W-1:0] out_sel;
    logic                                     frozen;
    logic                                     one_shot_used;
    prr_seq_t                                 seq;
    logic                                     wr_rejected;
    logic [`PRR_NUM_PINS-1:0]                 sync1;
    logic [`PRR_NUM_PINS-1:0]                 sync2;
    logic [`PRR_NUM_IN-1:0]                   periph_in;
    logic [`PRR_NUM_PINS-1:0]                 pin_out;
    logic [`PRR_NUM_PINS-1:0]                 pin_oe_n;
    logic [`PRR_NUM_PINS-1:0][1:0]            pin_thr;
  } prr_state_t;
endpackage

/* File: prr_router_monitor.sv */
// checker for the peripheral pin router, bound to every prr_router
// assumes: prr_pkg compiled first; sees only the router ports
`timescale 1ns/1ps
module prr_router_monitor
  import prr_pkg::*;
#(parameter bit LARGE_VARIANT = 1'b1) (
  // clock and resets
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   soft_reset,
  // configuration
  input wire prr_pkg::prr_cfg_wr_t   cfg_wr,
  input wire logic                   one_shot_lock_config,
  input wire logic                   routing_frozen_bit,
  input wire logic                   cfg_wr_rejected,
  // peripheral side
  input wire logic [31:0]            periph_dir_ovr_req,
  input wire logic                   two_wire_active,
  // port side
  input wire logic [23:0]            pin_direction_bit,
  input wire logic [23:0]            input_threshold_select,
  input wire logic [23:0]            pin_oe_n,
  input wire prr_pkg::prr_thr_t [23:0] pin_thr
);
  localparam logic [23:0] PRESENT = LARGE_VARIANT ? 24'hfff03f : 24'h3f003f;
  logic set_seen;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // helper and sequences
  always_ff @(posedge clk)
    if (rst || soft_reset) set_seen <= 1'b0;
    else if ($rose(routing_frozen_bit) && one_shot_lock_config) set_seen <= 1'b1;
  sequence s_key(logic [7:0] k);
    cfg_wr.we && cfg_wr.target == PRR_TGT_LOCK && cfg_wr.data == k && !soft_reset;
  endsequence
  sequence s_unlock;
    s_key(8'h55) ##1 !cfg_wr.we ##1 s_key(8'haa) ##1 !cfg_wr.we;
  endsequence
  // ==========================================================================
  // lock
  a_unlock_sets: assert property (s_unlock ##1 s_key(8'h01) |=> routing_frozen_bit)
    else $error("lock not set after unlock");
  a_lock_rise: assert property ($rose(routing_frozen_bit) |->
    $past(cfg_wr.we && cfg_wr.target == PRR_TGT_LOCK && cfg_wr.data[0]))
    else $error("lock set without lock write");
  a_lock_fall: assert property ($fell(routing_frozen_bit) |->
    $past(soft_reset || (cfg_wr.we && cfg_wr.target == PRR_TGT_LOCK && !cfg_wr.data[0])))
    else $error("lock cleared without cause");
  a_frozen_rejects: assert property (routing_frozen_bit && cfg_wr.we && !soft_reset &&
    cfg_wr.target inside {PRR_TGT_INPUT, PRR_TGT_OUTPUT} |=> cfg_wr_rejected)
    else $error("selection write while frozen not rejected");
  a_one_shot_keep: assert property (set_seen && one_shot_lock_config |-> !$fell(routing_frozen_bit))
    else $error("one-shot lock cleared");
  a_soft_unlocks: assert property (soft_reset && !cfg_wr.we |=> !routing_frozen_bit)
    else $error("lock kept over other reset");
  // ==========================================================================
  // pins
  a_oe_follows_dir: assert property (!two_wire_active && periph_dir_ovr_req == 32'h0 |=>
    pin_oe_n == ($past(pin_direction_bit) | ~PRESENT))
    else $error("driver enable not from direction");
  for (genvar i = 0; i < 24; i++) begin : g_pin
    if (PRESENT[i]) begin : g_on
      a_thr_level: assert property (!two_wire_active |=> pin_thr[i] ==
        ($past(input_threshold_select[i]) ? PRR_THR_SCHMITT : PRR_THR_TTL))
        else $error("input buffer not from level select");
      if (i != 19 && i != 20) begin : g_plain
        a_no_bus_buffer: assert property (pin_thr[i] != PRR_THR_TWO_WIRE)
          else $error("bus buffer on plain pin");
      end
    end
  end
endmodule // prr_router_monitor

bind prr_router prr_router_monitor #(.LARGE_VARIANT(LARGE_VARIANT)) prr_router_monitor_inst (
  .clk(clk), .rst(rst), .soft_reset(soft_reset), .cfg_wr(cfg_wr),
  .one_shot_lock_config(one_shot_lock_config), .routing_frozen_bit(routing_frozen_bit),
  .cfg_wr_rejected(cfg_wr_rejected), .periph_dir_ovr_req(periph_dir_ovr_req),
  .two_wire_active(two_wire_active), .pin_direction_bit(pin_direction_bit),
  .input_threshold_select(input_threshold_select), .pin_oe_n(pin_oe_n), .pin_thr(pin_thr));

/* File: prr_far_model.sv */
// far side: port pins resolved from router drive and outside levels
// assumes: outside levels change with every stimulus, so floats never hold
`timescale 1ns/1ps
module prr_far_model (
  // router pin side
  input  wire logic [23:0] pin_out,
  input  wire logic [23:0] pin_oe_n,
  // outside world
  input  wire logic [23:0] ext_level,
  output logic      [23:0] pin_in
);
  // driven pin shows router level, released pin the outside level
  always_comb
    for (int i = 0; i < 24; i++)
      pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
endmodule // prr_far_model

/* File: tb.sv */
// self-checking bench for prr_router with a queue-free reference model
// assumes: prr_pkg, prr_router, monitor and far model compiled before
`timescale 1ns/1ps
module tb;
  import prr_pkg::*;
  logic clk = 0, rst = 1, soft_reset = 0, one_shot_lock_config = 0, two_wire_active = 0;
  prr_cfg_wr_t cfg_wr = '0;
  logic [31:0] periph_out = '0, periph_dir_ovr_req = '0, periph_dir_ovr_oe_n = '1;
  logic [23:0] pin_in, port_latch = '0, pin_direction_bit = '1, input_threshold_select = '0, ext_level = '0;
  logic routing_frozen_bit, cfg_wr_rejected;
  logic [19:0] periph_in;
  logic [23:0] pin_out, pin_oe_n;
  prr_thr_t [23:0] pin_thr;
  int err_total = 0, n_checks = 0, cyc = 0, seq, frz, used;
  logic [5:0] in_sel [20], out_sel [24];
  logic [5:0] def_in [20] = '{6'h02, 6'h02, 6'h05, 6'h04, 6'h05, 6'h15, 6'h13, 6'h02, 6'h02, 6'h13,
                              6'h0c, 6'h0d, 6'h12, 6'h0e, 6'h0c, 6'h16, 6'h0d, 6'h0f, 6'h11, 6'h10};
  localparam logic [23:0] PRESENT = 24'hfff03f;
  // ==========================================================================
  // design and far side
  prr_router prr_router_inst (.clk(clk), .rst(rst), .soft_reset(soft_reset), .cfg_wr(cfg_wr),
    .one_shot_lock_config(one_shot_lock_config), .routing_frozen_bit(routing_frozen_bit),
    .cfg_wr_rejected(cfg_wr_rejected), .periph_out(periph_out), .periph_dir_ovr_req(periph_dir_ovr_req),
    .periph_dir_ovr_oe_n(periph_dir_ovr_oe_n), .two_wire_active(two_wire_active), .periph_in(periph_in),
    .pin_in(pin_in), .port_latch(port_latch), .pin_direction_bit(pin_direction_bit),
    .input_threshold_select(input_threshold_select), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_thr(pin_thr));
  prr_far_model prr_far_model_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level), .pin_in(pin_in));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      $display("mismatch at %0t: timeout", $time);
      stop_test;
    end
  end
  // ==========================================================================
  // tasks
  task check(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task por;
    @(posedge clk);
    #1 rst = 1;
    repeat (5) @(posedge clk);
    #1 rst = 0;
    in_sel = def_in;
    foreach (out_sel[i]) out_sel[i] = 6'h00;
    frz = 0; used = 0; seq = 0;
  endtask
  task wr(input prr_target_t t, input int i, input logic [7:0] d);
    logic er;
    er = 0;
    if (t == PRR_TGT_LOCK) begin
      if (seq == 2) begin
        if (!d[0] && one_shot_lock_config && used) er = 1;
        else begin frz = d[0]; used = used | (d[0] & one_shot_lock_config); end
        seq = 0;
      end else if (d == 8'h55) seq = 1;
      else if (d == 8'haa && seq == 1) seq = 2;
      else begin er = 1; seq = 0; end
    end else begin
      seq = 0;
      if (frz) er = (t != PRR_TGT_NONE);
      else if (t == PRR_TGT_INPUT && i < 20) in_sel[i] = d[5:0];
      else if (t == PRR_TGT_OUTPUT && i < 24 && PRESENT[i]) out_sel[i] = d[5:0];
    end
    @(posedge clk);
    #1 cfg_wr = '{1'b1, t, i[4:0], d};
    @(posedge clk);
    #1 cfg_wr.we = 1'b0;
    check(cfg_wr_rejected, er);
    check(routing_frozen_bit, frz);
  endtask
  task unlock(input logic [7:0] d);
    wr(PRR_TGT_LOCK, 0, 8'h55);
    wr(PRR_TGT_LOCK, 0, 8'haa);
    wr(PRR_TGT_LOCK, 0, d);
  endtask
  task route;
    logic [23:0] lv, eo, eoe;
    logic [19:0] ei;
    logic [47:0] et, tm;
    int c;
    @(posedge clk);
    #1 {pin_direction_bit, port_latch, ext_level, input_threshold_select} = {$urandom, $urandom, $urandom};
    periph_out = $urandom;
    repeat (6) @(posedge clk);
    #1;
    for (int i = 0; i < 24; i++) begin
      c = out_sel[i];
      eo[i] = PRESENT[i] & (((c >= 1 && c <= 22) || (c >= 25 && c <= 27)) ? periph_out[c] : port_latch[i]);
      eoe[i] = pin_direction_bit[i] | ~PRESENT[i];
      lv[i] = eoe[i] ? ext_level[i] : eo[i];
      et[2*i+:2] = input_threshold_select[i] ? PRR_THR_SCHMITT : PRR_THR_TTL;
      tm[2*i+:2] = PRESENT[i] ? 2'h3 : 2'h0;
    end
    for (int k = 0; k < 20; k++) begin
      c = in_sel[k];
      ei[k] = (c < 24 && PRESENT[c]) ? lv[c] : 1'b0;
    end
    check(periph_in, ei);
    check(pin_out, eo);
    check(pin_oe_n, eoe);
    check(48'(pin_thr) & tm, et & tm);
  endtask
  // ==========================================================================
  // scenarios
  initial begin
    void'($urandom(21));
    por;
    route;
    repeat (4) begin
      repeat (10) wr(prr_target_t'($urandom_range(1, 0)), $urandom_range(31, 0), 8'($urandom));
      route;
    end
    unlock(8'h01);
    wr(PRR_TGT_INPUT, 0, 8'h01);
    wr(PRR_TGT_OUTPUT, 0, 8'h05);
    route;
    wr(PRR_TGT_LOCK, 0, 8'h55);
    wr(PRR_TGT_LOCK, 0, 8'h00);
    wr(PRR_TGT_LOCK, 0, 8'h00);
    wr(PRR_TGT_LOCK, 0, 8'h55);
    wr(PRR_TGT_INPUT, 3, 8'h10);
    wr(PRR_TGT_LOCK, 0, 8'haa);
    wr(PRR_TGT_LOCK, 0, 8'h55);
    wr(PRR_TGT_NONE, 0, 8'h00);
    wr(PRR_TGT_LOCK, 0, 8'haa);
    unlock(8'h00);
    wr(PRR_TGT_INPUT, 0, 8'h10);
    route;
    one_shot_lock_config = 1;
    unlock(8'h00);
    unlock(8'h01);
    unlock(8'h00);
    @(posedge clk);
    #1 soft_reset = 1;
    @(posedge clk);
    #1 soft_reset = 0;
    frz = 0; used = 0; seq = 0;
    check(routing_frozen_bit, 1'b0);
    route;
    unlock(8'h01);
    unlock(8'h00);
    por;
    one_shot_lock_config = 0;
    check(routing_frozen_bit, 1'b0);
    route;
    wr(PRR_TGT_INPUT, 13, 8'h13);
    wr(PRR_TGT_INPUT, 14, 8'h01);
    wr(PRR_TGT_OUTPUT, 19, 8'h15);
    wr(PRR_TGT_OUTPUT, 1, 8'h16);
    two_wire_active = 1;
    periph_dir_ovr_req[21] = 1'b1;
    periph_dir_ovr_oe_n[21] = 1'b0;
    pin_direction_bit = '1;
    repeat (3) @(posedge clk);
    #1;
    check(pin_thr[19], PRR_THR_TWO_WIRE);
    check(pin_thr[1], input_threshold_select[1] ? PRR_THR_SCHMITT : PRR_THR_TTL);
    check(pin_oe_n[19], 1'b0);
    check(pin_out[19], periph_out[21]);
    check(pin_oe_n[1], 1'b1);
    stop_test;
  end
endmodule // tb
